// file: core/mpio_bank.sv
`timescale 1ns/1ns
`default_nettype none
// Six-port general purpose I/O bank behind an Avalon-MM slave
module mpio_bank (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Avalon-MM slave
    input  wire logic [6:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output var  logic [31:0] avs_readdata,
    output var  logic        avs_waitrequest,
    // System state
    input  wire logic        stop_mode,
    // Port B pins
    input  wire logic [2:0]  pin_b_in,
    output var  logic [2:0]  pin_b_out,
    output var  logic [2:0]  pin_b_oe_n,
    // Port C pins
    input  wire logic [7:0]  pin_c_in,
    output var  logic [7:0]  pin_c_out,
    output var  logic [7:0]  pin_c_oe_n,
    // Port D pins
    input  wire logic [7:0]  pin_d_in,
    output var  logic [7:0]  pin_d_out,
    output var  logic [7:0]  pin_d_oe_n,
    // Port E pins
    input  wire logic [4:0]  pin_e_in,
    output var  logic [4:0]  pin_e_out,
    output var  logic [4:0]  pin_e_oe_n,
    // Port F pins
    input  wire logic [7:0]  pin_f_in,
    output var  logic [7:0]  pin_f_out,
    output var  logic [7:0]  pin_f_oe_n,
    // Port G pins
    input  wire logic [7:0]  pin_g_in,
    output var  logic [7:0]  pin_g_out,
    output var  logic [7:0]  pin_g_oe_n,
    // Events and modes
    output var  logic        ext_int_pulse_ff,
    output var  logic        key_wakeup_ff,
    output var  logic        crystal_enable_ff
);

    // ----------------------------------------
    // Read decode shared by ports F and G
    // ----------------------------------------
    // Output bits read the latch, inputs the pin unless disabled
    function automatic logic [7:0] mpio_dir_read(input logic [7:0] data,
                                                input logic [7:0] dir,
                                                input logic [7:0] ie,
                                                input logic [7:0] pin);
        mpio_dir_read = (dir & data) | (~dir & ie & pin);
    endfunction : mpio_dir_read

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    mpio_pkg::mpio_bus_type bus_ff;   // Handshake state
    mpio_pkg::mpio_bus_type nxt_bus;
    logic [31:0]       nxt_readdata;  // Read word for the ack cycle
    logic              acc_wr;        // Write takes effect this edge
    logic [4:0]        noise_ff;      // Source of unstable upper bits
    logic [7:0]        f_data_ff;     // port_f_data
    logic [7:0]        f_dir_ff;      // port_f_direction
    logic [7:0]        f_ie_ff;       // port_f_input_enable
    logic [7:0]        f_kwe_ff;      // key_wakeup_enable
    logic [7:0]        g_data_ff;     // port_g_data
    logic [7:0]        g_dir_ff;      // port_g_direction
    logic [7:0]        g_ie_ff;       // port_g_input_enable
    logic [1:0]        ctrl_ff;       // Mode control
    logic              ext_int_ff;    // Sticky interrupt latch
    logic              b0_prev_ff;    // Previous pin B0 level
    logic [7:0]        nxt_f_data, nxt_f_dir, nxt_f_ie, nxt_f_kwe;
    logic [7:0]        nxt_g_data, nxt_g_dir, nxt_g_ie;
    logic [1:0]        nxt_ctrl;
    logic              nxt_ext_int, nxt_int_pulse, nxt_key_wake;
    logic [7:0]        nxt_f_out, nxt_f_oe_n, nxt_g_out, nxt_g_oe_n;
    logic              b0_fall;       // Falling edge on pin B0
    logic              oe_glob;       // Global output enable
    logic [2:0]        b_latch;       // port_b_output_latch
    logic [7:0]        c_latch;       // port_c_output_latch
    logic [7:0]        d_latch;       // port_d_output_latch
    logic [7:0]        d_sel_ff;      // port_d_drive_type_select
    logic [7:0]        nxt_d_sel;
    logic [4:0]        e_latch;       // port_e_output_latch
    logic [2:0]        b_off;         // Port B bits forced to float

    // ----------------------------------------
    // Bus handshake
    // ----------------------------------------
    // Every access waits exactly one cycle; the answer is fixed, not stalled
    always_comb begin
        acc_wr = avs_write && (bus_ff == mpio_pkg::BUS_ACK);
        unique case (bus_ff)
            mpio_pkg::BUS_IDLE: begin
                nxt_bus = (avs_read || avs_write) ? mpio_pkg::BUS_ACK : mpio_pkg::BUS_IDLE;
            end
            mpio_pkg::BUS_ACK: begin
                nxt_bus = mpio_pkg::BUS_IDLE;
            end
        endcase
    end

    // Handshake and noise registers
    always_ff @(posedge clk) begin
        if (!rstn) begin
            bus_ff          <= mpio_pkg::BUS_IDLE;
            avs_waitrequest <= 1'b1;
            noise_ff        <= 5'h00;
        end else begin
            bus_ff          <= nxt_bus;
            avs_waitrequest <= (nxt_bus != mpio_pkg::BUS_ACK);
            noise_ff        <= noise_ff + 5'h01;
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    // Captured while waitrequest is high so it stands when it drops
    always_comb begin
        nxt_readdata = 32'h0000_0000;  // Unmapped offsets read zero
        unique case (avs_address)
            mpio_pkg::OFS_B_LATCH: nxt_readdata[7:0] = {noise_ff, b_latch};
            mpio_pkg::OFS_B_PIN:   nxt_readdata[7:0] = {noise_ff, pin_b_in};
            mpio_pkg::OFS_C_LATCH: nxt_readdata[7:0] = c_latch;
            mpio_pkg::OFS_C_PIN:   nxt_readdata[7:0] = pin_c_in;
            mpio_pkg::OFS_D_LATCH: nxt_readdata[7:0] = d_latch;
            mpio_pkg::OFS_D_PIN:   nxt_readdata[7:0] = pin_d_in;
            mpio_pkg::OFS_D_SEL:   nxt_readdata[7:0] = d_sel_ff;
            mpio_pkg::OFS_E_LATCH: nxt_readdata[7:0] = {noise_ff[2:0], e_latch};
            mpio_pkg::OFS_E_PIN:   nxt_readdata[7:0] = {noise_ff[2:0], pin_e_in};
            mpio_pkg::OFS_F_DATA: begin
                nxt_readdata[7:0] = mpio_dir_read(f_data_ff, f_dir_ff, f_ie_ff, pin_f_in);
            end
            mpio_pkg::OFS_F_DIR:   nxt_readdata[7:0] = f_dir_ff;
            mpio_pkg::OFS_F_IE:    nxt_readdata[7:0] = f_ie_ff;
            mpio_pkg::OFS_F_KWE:   nxt_readdata[7:0] = f_kwe_ff;
            mpio_pkg::OFS_G_DATA: begin
                nxt_readdata[7:0] = mpio_dir_read(g_data_ff, g_dir_ff, g_ie_ff, pin_g_in);
            end
            mpio_pkg::OFS_G_DIR:   nxt_readdata[7:0] = g_dir_ff;
            mpio_pkg::OFS_G_IE:    nxt_readdata[7:0] = g_ie_ff;
            mpio_pkg::OFS_CTRL:    nxt_readdata[1:0] = ctrl_ff;
            mpio_pkg::OFS_STAT:    nxt_readdata[mpio_pkg::STAT_EXT_INT] = ext_int_ff;
            default:               nxt_readdata = 32'h0000_0000;
        endcase
    end

    // Read data register
    always_ff @(posedge clk) begin
        if (!rstn) begin
            avs_readdata <= 32'h0000_0000;
        end else if (bus_ff == mpio_pkg::BUS_IDLE) begin
            avs_readdata <= nxt_readdata;
        end
    end

    // ----------------------------------------
    // Control registers and events
    // ----------------------------------------
    // Only the low byte is stored; higher write data is dropped
    always_comb begin
        nxt_f_data = f_data_ff;
        nxt_f_dir  = f_dir_ff;
        nxt_f_ie   = f_ie_ff;
        nxt_f_kwe  = f_kwe_ff;
        nxt_g_data = g_data_ff;
        nxt_g_dir  = g_dir_ff;
        nxt_g_ie   = g_ie_ff;
        nxt_d_sel  = d_sel_ff;
        nxt_ctrl   = ctrl_ff;
        nxt_ext_int = ext_int_ff;
        if (acc_wr) begin
            unique case (avs_address)
                mpio_pkg::OFS_D_SEL:  nxt_d_sel  = avs_writedata[7:0];
                mpio_pkg::OFS_F_DATA: nxt_f_data = avs_writedata[7:0];
                mpio_pkg::OFS_F_DIR:  nxt_f_dir  = avs_writedata[7:0];
                mpio_pkg::OFS_F_IE:   nxt_f_ie   = avs_writedata[7:0];
                mpio_pkg::OFS_F_KWE:  nxt_f_kwe  = avs_writedata[7:0];
                mpio_pkg::OFS_G_DATA: nxt_g_data = avs_writedata[7:0];
                mpio_pkg::OFS_G_DIR:  nxt_g_dir  = avs_writedata[7:0];
                mpio_pkg::OFS_G_IE:   nxt_g_ie   = avs_writedata[7:0];
                mpio_pkg::OFS_CTRL:   nxt_ctrl   = avs_writedata[1:0];
                mpio_pkg::OFS_STAT: begin
                    // Write one to clear
                    if (avs_writedata[mpio_pkg::STAT_EXT_INT]) begin
                        nxt_ext_int = 1'b0;
                    end
                end
                default: begin
                    // Unmapped or latch-port offsets: nothing here
                end
            endcase
        end
        // The pin follows the driven level when B0 is an output as well
        b0_fall = b0_prev_ff && !pin_b_in[0];
        if (b0_fall) begin
            nxt_ext_int = 1'b1;
        end
        nxt_int_pulse = b0_fall;
        // Wakeup ignores latch and input enable on input bits
        nxt_key_wake = |(~f_dir_ff & f_kwe_ff & pin_f_in);
    end

    // Control registers
    always_ff @(posedge clk) begin
        if (!rstn) begin
            f_data_ff <= mpio_pkg::RST_DATA;
            f_dir_ff  <= mpio_pkg::RST_DIR;
            f_ie_ff   <= mpio_pkg::RST_IE;
            f_kwe_ff  <= mpio_pkg::RST_KWE;
            g_data_ff <= mpio_pkg::RST_DATA;
            g_dir_ff  <= mpio_pkg::RST_DIR;
            g_ie_ff   <= mpio_pkg::RST_IE;
            d_sel_ff  <= mpio_pkg::RST_D_SEL;
            ctrl_ff   <= mpio_pkg::RST_CTRL;
            ext_int_ff        <= 1'b0;
            b0_prev_ff        <= 1'b1;
            ext_int_pulse_ff  <= 1'b0;
            key_wakeup_ff     <= 1'b0;
            crystal_enable_ff <= 1'b0;
        end else begin
            f_data_ff <= nxt_f_data;
            f_dir_ff  <= nxt_f_dir;
            f_ie_ff   <= nxt_f_ie;
            f_kwe_ff  <= nxt_f_kwe;
            g_data_ff <= nxt_g_data;
            g_dir_ff  <= nxt_g_dir;
            g_ie_ff   <= nxt_g_ie;
            d_sel_ff  <= nxt_d_sel;
            ctrl_ff   <= nxt_ctrl;
            ext_int_ff        <= nxt_ext_int;
            b0_prev_ff        <= pin_b_in[0];
            ext_int_pulse_ff  <= nxt_int_pulse;
            key_wakeup_ff     <= nxt_key_wake;
            crystal_enable_ff <= nxt_ctrl[mpio_pkg::CTRL_DUAL_CLK];
        end
    end

    // ----------------------------------------
    // Pin drive for ports F and G
    // ----------------------------------------
    // Direction one drives the data latch while outputs are enabled
    always_comb begin
        oe_glob    = ctrl_ff[mpio_pkg::CTRL_OUT_EN];
        nxt_f_out  = f_data_ff;
        nxt_f_oe_n = ~(f_dir_ff & {8{oe_glob}});
        nxt_g_out  = g_data_ff;
        nxt_g_oe_n = ~(g_dir_ff & {8{oe_glob}});
        // STOP floats B0 no matter the global enable
        b_off[0] = !oe_glob || stop_mode;
        // Crystal pins are released to the oscillator in dual clock mode
        b_off[1] = !oe_glob || ctrl_ff[mpio_pkg::CTRL_DUAL_CLK];
        b_off[2] = !oe_glob || ctrl_ff[mpio_pkg::CTRL_DUAL_CLK];
    end

    // Port F and G pin registers
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pin_f_out  <= 8'h00;
            pin_f_oe_n <= 8'hff;
            pin_g_out  <= 8'h00;
            pin_g_oe_n <= 8'hff;
        end else begin
            pin_f_out  <= nxt_f_out;
            pin_f_oe_n <= nxt_f_oe_n;
            pin_g_out  <= nxt_g_out;
            pin_g_oe_n <= nxt_g_oe_n;
        end
    end

    // ----------------------------------------
    // Latch-only ports B to E
    // ----------------------------------------
    // Port B: three sink-only bits, upper write bits dropped
    mpio_latch_port #(.W(mpio_pkg::B_W), .RST(mpio_pkg::RST_B_LATCH)) u_port_b (
        .clk         (clk),
        .rstn        (rstn),
        .wr_en       (acc_wr && avs_address == mpio_pkg::OFS_B_LATCH),
        .wr_data     (avs_writedata[2:0]),
        .push_pull   (3'h0),
        .force_off   (b_off),
        .latch_ff    (b_latch),
        .pin_out_ff  (pin_b_out),
        .pin_oe_n_ff (pin_b_oe_n)
    );

    // Port C: large-current sink port
    mpio_latch_port #(.W(mpio_pkg::C_W), .RST(mpio_pkg::RST_C_LATCH)) u_port_c (
        .clk         (clk),
        .rstn        (rstn),
        .wr_en       (acc_wr && avs_address == mpio_pkg::OFS_C_LATCH),
        .wr_data     (avs_writedata[7:0]),
        .push_pull   (8'h00),
        .force_off   ({8{!oe_glob}}),
        .latch_ff    (c_latch),
        .pin_out_ff  (pin_c_out),
        .pin_oe_n_ff (pin_c_oe_n)
    );

    // Port D: drive type chosen per bit
    mpio_latch_port #(.W(mpio_pkg::D_W), .RST(mpio_pkg::RST_D_LATCH)) u_port_d (
        .clk         (clk),
        .rstn        (rstn),
        .wr_en       (acc_wr && avs_address == mpio_pkg::OFS_D_LATCH),
        .wr_data     (avs_writedata[7:0]),
        .push_pull   (d_sel_ff),
        .force_off   ({8{!oe_glob}}),
        .latch_ff    (d_latch),
        .pin_out_ff  (pin_d_out),
        .pin_oe_n_ff (pin_d_oe_n)
    );

    // Port E: five bits, upper write bits dropped
    mpio_latch_port #(.W(mpio_pkg::E_W), .RST(mpio_pkg::RST_E_LATCH)) u_port_e (
        .clk         (clk),
        .rstn        (rstn),
        .wr_en       (acc_wr && avs_address == mpio_pkg::OFS_E_LATCH),
        .wr_data     (avs_writedata[4:0]),
        .push_pull   (5'h00),
        .force_off   ({5{!oe_glob}}),
        .latch_ff    (e_latch),
        .pin_out_ff  (pin_e_out),
        .pin_oe_n_ff (pin_e_oe_n)
    );

endmodule : mpio_bank
`default_nettype wire

// file: shared/mpio_pkg.sv
// How it works
// - Reset sets port B latch to ones
// - Dual clock mode gives B1, B2 to crystal
// - Falling edge on B0 sets interrupt latch
// - Port B read bits 7..3 are unstable
// - STOP floats B0 regardless of output enable
// - Port C: eight bits, latch resets to ones
// - Port D latch resets ones, select zero
// - Select zero open drain, one push-pull
// - Port E five bits, ones, 7..5 unstable
// - Port F resets dir/data zero, enable ones
// - Port F direction one drives the latch
// - Port F read: zero, pin, or latch
// - Port F input with wakeup enable wakes
// - Port G resets like F, one is output
// - Port G read: zero, pin, or latch
// - Ports B to E: latch and pin state at separate addresses
package mpio_pkg;

    // ----------------------------------------
    // Port widths
    // ----------------------------------------
    localparam int unsigned B_W = 3;
    localparam int unsigned C_W = 8;
    localparam int unsigned D_W = 8;
    localparam int unsigned E_W = 5;
    localparam int unsigned F_W = 8;
    localparam int unsigned G_W = 8;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [6:0] OFS_B_LATCH = 7'h00;  // port_b_output_latch
    localparam logic [6:0] OFS_B_PIN   = 7'h04;  // port_b_pin_read
    localparam logic [6:0] OFS_C_LATCH = 7'h08;  // port_c_output_latch
    localparam logic [6:0] OFS_C_PIN   = 7'h0c;  // port_c_pin_read
    localparam logic [6:0] OFS_D_LATCH = 7'h10;  // port_d_output_latch
    localparam logic [6:0] OFS_D_PIN   = 7'h14;  // port_d_pin_read
    localparam logic [6:0] OFS_D_SEL   = 7'h18;  // port_d_drive_type_select
    localparam logic [6:0] OFS_E_LATCH = 7'h1c;  // port_e_output_latch
    localparam logic [6:0] OFS_E_PIN   = 7'h20;  // port_e_pin_read
    localparam logic [6:0] OFS_F_DATA  = 7'h24;  // port_f_data
    localparam logic [6:0] OFS_F_DIR   = 7'h28;  // port_f_direction
    localparam logic [6:0] OFS_F_IE    = 7'h2c;  // port_f_input_enable
    localparam logic [6:0] OFS_F_KWE   = 7'h30;  // key_wakeup_enable
    localparam logic [6:0] OFS_G_DATA  = 7'h34;  // port_g_data
    localparam logic [6:0] OFS_G_DIR   = 7'h38;  // port_g_direction
    localparam logic [6:0] OFS_G_IE    = 7'h3c;  // port_g_input_enable
    localparam logic [6:0] OFS_CTRL    = 7'h40;  // Mode control
    localparam logic [6:0] OFS_STAT    = 7'h44;  // Event status

    // ----------------------------------------
    // Control and status fields
    // ----------------------------------------
    localparam int unsigned CTRL_DUAL_CLK = 0;   // Dual clock mode
    localparam int unsigned CTRL_OUT_EN   = 1;   // global_output_enable
    localparam int unsigned STAT_EXT_INT  = 0;   // External interrupt latch

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [B_W-1:0] RST_B_LATCH = 3'h7;
    localparam logic [C_W-1:0] RST_C_LATCH = 8'hff;
    localparam logic [D_W-1:0] RST_D_LATCH = 8'hff;
    localparam logic [D_W-1:0] RST_D_SEL   = 8'h00;
    localparam logic [E_W-1:0] RST_E_LATCH = 5'h1f;
    localparam logic [7:0]     RST_DATA    = 8'h00;
    localparam logic [7:0]     RST_DIR     = 8'h00;
    localparam logic [7:0]     RST_IE      = 8'hff;
    localparam logic [7:0]     RST_KWE     = 8'h00;
    localparam logic [1:0]     RST_CTRL    = 2'h2;  // Single clock, outputs on

    // ----------------------------------------
    // Bus handshake states
    // ----------------------------------------
    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,  // Waitrequest high, request seen
        BUS_ACK  = 1'b1   // Waitrequest low for one cycle
    } mpio_bus_type;

endpackage : mpio_pkg

// file: core/mpio_latch_port.sv
`timescale 1ns/1ns
`default_nettype none
// Output latch with registered pin drive for one latch-only port
module mpio_latch_port #(
    parameter int unsigned    W   = 8,
    parameter logic [W-1:0]   RST = '1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rstn,
    // Latch write
    input  wire logic         wr_en,
    input  wire logic [W-1:0] wr_data,
    // Drive control
    input  wire logic [W-1:0] push_pull,   // One drives high as well as low
    input  wire logic [W-1:0] force_off,   // One floats the pin
    // Outputs
    output var  logic [W-1:0] latch_ff,
    output var  logic [W-1:0] pin_out_ff,
    output var  logic [W-1:0] pin_oe_n_ff
);

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    logic [W-1:0] nxt_latch;     // Latch next value
    logic [W-1:0] nxt_pin_out;   // Pin level next value
    logic [W-1:0] nxt_pin_oe_n;  // Pin enable next value

    // Latch update and drive decision per bit
    always_comb begin
        nxt_latch = wr_en ? wr_data : latch_ff;
        nxt_pin_out = latch_ff;
        // Sink-only bits drive only a low; a one releases the pin
        nxt_pin_oe_n = force_off | ~(push_pull | ~latch_ff);
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    // Latch resets to the port's default, pins start floating
    always_ff @(posedge clk) begin
        if (!rstn) begin
            latch_ff    <= RST;
            pin_out_ff  <= '0;
            pin_oe_n_ff <= '1;
        end else begin
            latch_ff    <= nxt_latch;
            pin_out_ff  <= nxt_pin_out;
            pin_oe_n_ff <= nxt_pin_oe_n;
        end
    end

endmodule : mpio_latch_port
`default_nettype wire

// file: verif/mpio_pins_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Board side of all bank pins
// ----------------------------------------
module mpio_pins_model #(
    parameter int unsigned W = 40
) (
    // Bank drive and board level
    input  wire logic [W-1:0] pin_out,
    input  wire logic [W-1:0] pin_oe_n,
    input  wire logic [W-1:0] ext_level,
    // Level seen back by the bank
    output var  logic [W-1:0] pin_in
);
    // Released bits take the board level, which the bench keeps changing
    always_comb pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_level);
endmodule : mpio_pins_model
`default_nettype wire

// file: verif/mpio_props.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Pin and bus checks of the bank
// ----------------------------------------
module mpio_props (
    input wire logic       clk, rstn, avs_read, avs_write, avs_waitrequest, stop_mode,
    input wire logic [2:0] pin_b_in, pin_b_oe_n,
    input wire logic [7:0] pin_c_out, pin_c_oe_n, pin_d_oe_n, pin_f_oe_n, pin_g_oe_n,
    input wire logic [4:0] pin_e_out, pin_e_oe_n,
    input wire logic       ext_int_pulse_ff, crystal_enable_ff
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Request still waiting for its answer
    sequence req_s; (avs_read || avs_write) && avs_waitrequest; endsequence
    // Falling level on the lowest port B pin
    sequence fall_s; $fell(pin_b_in[0]); endsequence
    bus_answer_a: assert property (req_s |=> !avs_waitrequest) else $error("bus not answered");
    ack_single_a: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("long ack");
    reset_float_a: assert property ($rose(rstn) |-> &{pin_b_oe_n, pin_c_oe_n,
        pin_d_oe_n, pin_e_oe_n, pin_f_oe_n, pin_g_oe_n}) else $error("pin driven after reset");
    stop_float_a: assert property (stop_mode && $past(stop_mode) |-> pin_b_oe_n[0])
        else $error("stop pin driven");
    xtal_float_a: assert property (crystal_enable_ff && $past(crystal_enable_ff)
        |-> &pin_b_oe_n[2:1]) else $error("crystal pins driven");
    int_fire_a: assert property (fall_s |=> ext_int_pulse_ff) else $error("edge missed");
    int_cause_a: assert property (ext_int_pulse_ff
        |-> $past(pin_b_in[0], 2) && !$past(pin_b_in[0])) else $error("event without edge");
    // Sink-only ports C and E never drive a high level
    sink_only_a: assert property (((~pin_c_oe_n & pin_c_out) == 8'h00)
        && ((~pin_e_oe_n & pin_e_out) == 5'h00)) else $error("sink port drives high");
endmodule : mpio_props
`default_nettype wire

// file: verif/testbench.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Self-checking bench of the bank
// ----------------------------------------
module testbench;
    logic        clk = 1'b0, rstn = 1'b0, avs_read = 1'b0, avs_write = 1'b0, stop_mode = 1'b0;
    logic [6:0]  avs_address = 7'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic        avs_waitrequest, ext_int_pulse_ff, key_wakeup_ff, crystal_enable_ff;
    logic [2:0]  pin_b_out, pin_b_oe_n;
    logic [4:0]  pin_e_out, pin_e_oe_n;
    logic [7:0]  pin_c_out, pin_c_oe_n, pin_d_out, pin_d_oe_n, pin_f_out, pin_f_oe_n;
    logic [7:0]  pin_g_out, pin_g_oe_n;
    wire logic [2:0] pin_b_in;
    wire logic [4:0] pin_e_in;
    wire logic [7:0] pin_c_in, pin_d_in, pin_f_in, pin_g_in;
    logic [39:0] ext = 40'hff_ffff_ffff;  // Board level of released pins
    logic [7:0]  mdl [18];                // Reference copy of each word offset
    int          fails = 0, num_checks = 0;
    // Reset values and writable bits per word offset
    localparam logic [7:0] RV [18] = '{8'h07, 8'h00, 8'hff, 8'h00, 8'hff, 8'h00, 8'h00, 8'h1f,
        8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'hff, 8'h02, 8'h00};
    localparam logic [7:0] WM [18] = '{8'h07, 8'h00, 8'hff, 8'h00, 8'hff, 8'h00, 8'hff, 8'h1f,
        8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h03, 8'h01};
    mpio_bank dut_u (.*);
    mpio_pins_model pm_u (
        .pin_out({pin_g_out, pin_f_out, pin_e_out, pin_d_out, pin_c_out, pin_b_out}),
        .pin_oe_n({pin_g_oe_n, pin_f_oe_n, pin_e_oe_n, pin_d_oe_n, pin_c_oe_n, pin_b_oe_n}),
        .ext_level(ext),
        .pin_in({pin_g_in, pin_f_in, pin_e_in, pin_d_in, pin_c_in, pin_b_in}));
    initial forever #4 clk = ~clk;
    // Expected read value; sink ports show latch AND board level
    function automatic logic [7:0] exp_rd(input int i);
        case (i)
            1: return mdl[0] & ext[2:0];
            3: return mdl[2] & ext[10:3];
            5: return mdl[4] & (mdl[6] | ext[18:11]);
            8: return mdl[7] & ext[23:19];
            9: return (mdl[10] & mdl[9]) | (~mdl[10] & mdl[11] & ext[31:24]);
            13: return (mdl[14] & mdl[13]) | (~mdl[14] & mdl[15] & ext[39:32]);
            18: return 8'h00;
            default: return mdl[i];
        endcase
    endfunction : exp_rd
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic finish_test();
        if (fails == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : finish_test
    // One Avalon access; held until waitrequest is seen low
    task automatic bus(input logic wr, input int i, input logic [7:0] d);
        int n;
        n = 0;
        avs_address <= 7'(i * 4);
        avs_writedata <= {24'h0, d};
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        rd = avs_readdata;
        if (n >= 40) begin
            fails++;
            finish_test();
        end
        if (wr && i < 18) mdl[i] = d & WM[i];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask : bus
    // Unstable upper bits of ports B and E are masked off
    task automatic rd_chk(input int i);
        bus(1'b0, i, 8'h00);
        chk(rd & ((i < 2) ? 32'h7 : (i == 7 || i == 8) ? 32'h1f : 32'hffff_ffff), exp_rd(i));
    endtask : rd_chk
    task automatic reset_chk();
        repeat (16) @(posedge clk);
        mdl = RV;
        rstn <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 19; i++) rd_chk(i);
    endtask : reset_chk
    initial begin
        void'($urandom(65707));
        reset_chk();
        repeat (6) begin
            ext <= 40'({$urandom(), $urandom()});
            for (int i = 0; i < 19; i++) if (i < 16 || i == 18) bus(1'b1, i, 8'($urandom()));
            repeat (4) @(posedge clk);
            for (int i = 0; i < 16; i++) rd_chk(i);
            chk({pin_b_oe_n, pin_c_oe_n, pin_e_oe_n}, {mdl[0][2:0], mdl[2], mdl[7][4:0]});
            chk({pin_d_oe_n, pin_d_out & ~pin_d_oe_n}, {mdl[4] & ~mdl[6], mdl[4] & mdl[6]});
            chk({pin_f_oe_n, pin_g_oe_n, pin_f_out & ~pin_f_oe_n, pin_g_out & ~pin_g_oe_n},
                {~mdl[10], ~mdl[14], mdl[9] & mdl[10], mdl[13] & mdl[14]});
            chk(key_wakeup_ff, |(~mdl[10] & mdl[12] & ext[31:24]));
        end
        ext <= 40'hff_ffff_ffff;
        bus(1'b1, 4, 8'hff);
        bus(1'b1, 6, 8'h00);
        rd_chk(5);
        bus(1'b1, 10, 8'h00);
        bus(1'b1, 11, 8'h00);
        bus(1'b1, 14, 8'h00);
        bus(1'b1, 15, 8'h00);
        rd_chk(9);
        rd_chk(13);
        bus(1'b1, 0, 8'h07);
        bus(1'b1, 17, 8'h01);
        bus(1'b1, 0, 8'h00);
        // The edge reaches the status flag one cycle after the pin drops
        repeat (2) @(posedge clk);
        bus(1'b0, 17, 8'h00);
        chk(rd, 32'h1);
        bus(1'b1, 17, 8'h01);
        bus(1'b0, 17, 8'h00);
        chk(rd, 32'h0);
        stop_mode <= 1'b1;
        repeat (3) @(posedge clk);
        chk(pin_b_oe_n, 32'h1);
        stop_mode <= 1'b0;
        bus(1'b1, 16, 8'h03);
        repeat (3) @(posedge clk);
        chk({crystal_enable_ff, pin_b_oe_n}, 32'he);
        bus(1'b1, 16, 8'h00);
        repeat (3) @(posedge clk);
        chk(&{pin_b_oe_n, pin_c_oe_n, pin_d_oe_n, pin_e_oe_n, pin_f_oe_n, pin_g_oe_n}, 32'h1);
        bus(1'b1, 16, 8'h02);
        repeat (3) @(posedge clk);
        chk({crystal_enable_ff, pin_b_oe_n}, 32'h0);
        rstn <= 1'b0;
        reset_chk();
        finish_test();
    end
endmodule : testbench
bind mpio_bank mpio_props chk_u (.*);
`default_nettype wire
